// ==== logic/albe_core.sv ====
// Purpose: executes arithmetic, logic, compare and control-transfer ops
// Assumes: prog_data is the word at prog_addr, same clock, no latency
// Notes:   unknown opcodes advance the pc and retire like a no-op
`timescale 1ns/1ps
module albe_core
(
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic [albe_pkg::INS_W-1:0] prog_data,
    input  wire logic [4:0]                 dbg_sel,
    output logic      [albe_pkg::PC_W-1:0]  prog_addr,
    output logic      [7:0]                 sreg_out,
    output logic      [7:0]                 dbg_data,
    output logic                            retire
);
    import albe_pkg::*;

    albe_st_s          cur;
    albe_st_s          nxt;
    logic [15:0]       ins;
    logic [5:0]        top6;
    logic [3:0]        top4;
    logic [4:0]        fd;
    logic [4:0]        fr;
    logic [4:0]        fi;
    logic [4:0]        fw;
    logic [7:0]        va;
    logic [7:0]        vb;
    logic [7:0]        vi;
    logic [7:0]        kk;
    logic [15:0]       kw;
    logic [15:0]       pairv;
    logic [16:0]       wsum;
    logic [15:0]       rel_tgt;
    logic [8:0]        chk_adc;
    logic              ex;
    logic              op_add;
    logic              op_sub;
    logic              op_cmp;
    logic              op_ksub;
    logic              op_log;
    logic              op_one;
    logic              op_inv;
    logic              op_ainv;
    logic              op_inc;
    logic              op_min;
    logic              op_ones;
    logic              op_wadd;
    logic              op_wsub;
    logic              op_relj;
    logic              op_relc;
    logic              op_pjmp;
    logic              op_ptrc;
    logic              op_lsub;
    logic              op_lint;
    logic              op_eqsk;
    logic [10:0]       ar;
    logic [7:0]        res;

    // {carry, half carry, overflow, result}
    function automatic logic [10:0] alu8(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       ci,
                                         input logic       sub);
        logic [8:0] s;
        logic [4:0] n;
        logic       v;
        if (sub)
        begin
            s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
            n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
            v = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
        end
        else
        begin
            s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
            n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
            v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
        end
        return {s[8], n[4], v, s[7:0]};
    endfunction

    function automatic logic [7:0] fl_ar(input logic [7:0]  s,
                                         input logic [10:0] a);
        logic [7:0] f;
        f        = s;
        f[FLG_C] = a[10];
        f[FLG_H] = a[9];
        f[FLG_V] = a[8];
        f[FLG_N] = a[7];
        f[FLG_Z] = (a[7:0] == ZERO_B);
        return f;
    endfunction

    function automatic logic [7:0] fl_lg(input logic [7:0] s,
                                         input logic [7:0] r,
                                         input logic       v);
        logic [7:0] f;
        f        = s;
        f[FLG_V] = v;
        f[FLG_N] = r[7];
        f[FLG_Z] = (r == ZERO_B);
        return f;
    endfunction

    // double-word opcodes must be stepped over whole by a skip
    function automatic logic is2w(input logic [15:0] w);
        return ((w & TW_M0) == TW_V0) || ((w & TW_M1) == TW_V1);
    endfunction

    assign ins     = prog_data;
    assign top6    = ins[15:10];
    assign top4    = ins[15:12];
    assign fd      = ins[8:4];
    assign fr      = {ins[9], ins[3:0]};
    assign fi      = {1'b1, ins[7:4]};
    assign fw      = {2'b11, ins[5:4], 1'b0};
    assign va      = cur.gpr[fd];
    assign vb      = cur.gpr[fr];
    assign vi      = cur.gpr[fi];
    assign kk      = {ins[11:8], ins[3:0]};
    assign kw      = {10'h000, ins[7:6], ins[3:0]};
    assign pairv   = {cur.gpr[fw | 5'h01], cur.gpr[fw]};
    assign wsum    = op_wsub ? {1'b0, pairv} - {1'b0, kw}
                             : {1'b0, pairv} + {1'b0, kw};
    assign rel_tgt = cur.pc + {{4{ins[11]}}, ins[11:0]} + 16'h0001;
    assign chk_adc = {1'b0, va} + {1'b0, vb} + {8'h00, cur.sreg[FLG_C]};
    assign ex      = (cur.st == ST_RUN);

    assign op_add   = (top6 == OP_ADD) || (top6 == OP_ADC);
    assign op_cmp   = (top6 == OP_CMP) || (top6 == OP_CMPB);
    assign op_sub   = (top6 == OP_SUB) || (top6 == OP_SUBB) || op_cmp;
    assign op_ksub  = (top4 == OP_KSUB) || (top4 == OP_KSBB);
    assign op_log   = (top6 == OP_AND) || (top6 == OP_XOR)
                   || (top6 == OP_OR) || (top4 == OP_KAND)
                   || (top4 == OP_KOR);
    assign op_one   = (ins[15:9] == OP_ONE);
    assign op_inv   = op_one && (ins[3:0] == ONE_INV);
    assign op_ainv  = op_one && (ins[3:0] == ONE_AINV);
    assign op_inc   = op_one && (ins[3:0] == ONE_INC);
    assign op_min   = op_one && (ins[3:0] == ONE_MIN);
    assign op_ones  = (top4 == OP_LDI) && (kk == ALL_ONES);
    assign op_wadd  = (ins[15:8] == OP_WADD);
    assign op_wsub  = (ins[15:8] == OP_WSUB);
    assign op_relj  = (top4 == OP_RELJ);
    assign op_relc  = (top4 == OP_RCAL);
    assign op_pjmp  = (ins == OP_PJMP);
    assign op_ptrc  = (ins == OP_ICAL);
    assign op_lsub  = (ins == OP_LSUB);
    assign op_lint  = (ins == OP_LINT);
    assign op_eqsk  = (top6 == OP_EQSK);

    always_comb
    begin
        nxt        = cur;
        ar         = 11'h000;
        res        = 8'h00;
        nxt.retire = 1'b0;
        nxt.dbg    = cur.gpr[dbg_sel];
        unique case (cur.st)
            ST_RUN:
            begin
                nxt.pc     = cur.pc + 16'h0001;
                nxt.retire = 1'b1;
                if (op_add)
                begin
                    ar = alu8(va, vb, (top6 == OP_ADC) & cur.sreg[FLG_C],
                              1'b0);
                    nxt.gpr[fd] = ar[7:0];
                    nxt.sreg    = fl_ar(cur.sreg, ar);
                end
                else if (op_sub)
                begin
                    ar = alu8(va, vb, ((top6 == OP_SUBB) || (top6 == OP_CMPB))
                              & cur.sreg[FLG_C], 1'b1);
                    // compares keep the destination untouched
                    if (!op_cmp)
                        nxt.gpr[fd] = ar[7:0];
                    nxt.sreg = fl_ar(cur.sreg, ar);
                end
                else if (op_ksub)
                begin
                    ar = alu8(vi, kk, (top4 == OP_KSBB) & cur.sreg[FLG_C],
                              1'b1);
                    nxt.gpr[fi] = ar[7:0];
                    nxt.sreg    = fl_ar(cur.sreg, ar);
                end
                else if (op_log)
                begin
                    // mask clear arrives already inverted in the constant
                    unique case (1'b1)
                        (top6 == OP_AND): res = va & vb;
                        (top6 == OP_XOR): res = va ^ vb;
                        (top6 == OP_OR):  res = va | vb;
                        (top4 == OP_KAND): res = vi & kk;
                        default:          res = vi | kk;
                    endcase
                    if ((top4 == OP_KAND) || (top4 == OP_KOR))
                        nxt.gpr[fi] = res;
                    else
                        nxt.gpr[fd] = res;
                    nxt.sreg = fl_lg(cur.sreg, res, 1'b0);
                end
                else if (op_inv)
                begin
                    res             = ALL_ONES - va;
                    nxt.gpr[fd]     = res;
                    nxt.sreg        = fl_lg(cur.sreg, res, 1'b0);
                    nxt.sreg[FLG_C] = 1'b1;
                end
                else if (op_ainv)
                begin
                    ar          = alu8(ZERO_B, va, 1'b0, 1'b1);
                    nxt.gpr[fd] = ar[7:0];
                    nxt.sreg    = fl_ar(cur.sreg, ar);
                end
                else if (op_inc || op_min)
                begin
                    ar          = alu8(va, 8'h01, 1'b0, op_min);
                    nxt.gpr[fd] = ar[7:0];
                    nxt.sreg    = fl_lg(cur.sreg, ar[7:0], ar[8]);
                end
                else if (op_ones)
                begin
                    nxt.gpr[fi] = ALL_ONES;
                end
                else if (op_wadd || op_wsub)
                begin
                    // whole pair written at once, second cycle only waits
                    nxt.gpr[fw]        = wsum[7:0];
                    nxt.gpr[fw | 5'h01] = wsum[15:8];
                    nxt.sreg[FLG_C]    = wsum[16];
                    nxt.sreg[FLG_N]    = wsum[15];
                    nxt.sreg[FLG_Z]    = (wsum[15:0] == 16'h0000);
                    nxt.sreg[FLG_V]    = op_wsub ? (pairv[15] & ~wsum[15])
                                                 : (~pairv[15] & wsum[15]);
                    nxt.sreg[FLG_S]    = wsum[15] ^ nxt.sreg[FLG_V];
                    nxt.st             = ST_WAIT;
                    nxt.wcnt           = W_WORD;
                    nxt.retire         = 1'b0;
                end
                else if (op_relj || op_pjmp)
                begin
                    nxt.pc     = op_relj ? rel_tgt
                                         : {cur.gpr[Z_HI], cur.gpr[Z_LO]};
                    nxt.st     = ST_WAIT;
                    nxt.wcnt   = W_JMP;
                    nxt.retire = 1'b0;
                end
                else if (op_relc || op_ptrc)
                begin
                    // stack wraps silently when nested deeper than STK_D
                    nxt.stk[cur.sp] = cur.pc + 16'h0001;
                    nxt.sp          = cur.sp + 3'h1;
                    nxt.pc          = op_relc ? rel_tgt
                                         : {cur.gpr[Z_HI], cur.gpr[Z_LO]};
                    nxt.st          = ST_WAIT;
                    nxt.wcnt        = W_CALL;
                    nxt.retire      = 1'b0;
                end
                else if (op_lsub || op_lint)
                begin
                    nxt.pc     = cur.stk[cur.sp - 3'h1];
                    nxt.sp     = cur.sp - 3'h1;
                    nxt.st     = ST_WAIT;
                    nxt.wcnt   = W_RET;
                    nxt.retire = 1'b0;
                    if (op_lint)
                        nxt.sreg[FLG_I] = 1'b1;
                end
                else if (op_eqsk && (va == vb))
                begin
                    nxt.st     = ST_SKIP;
                    nxt.retire = 1'b0;
                end
            end
            ST_WAIT:
            begin
                nxt.wcnt = cur.wcnt - 2'h1;
                if (cur.wcnt == 2'h1)
                begin
                    nxt.st     = ST_RUN;
                    nxt.retire = 1'b1;
                end
            end
            ST_SKIP:
            begin
                if (is2w(ins))
                begin
                    nxt.pc   = cur.pc + 16'h0002;
                    nxt.st   = ST_WAIT;
                    nxt.wcnt = 2'h1;
                end
                else
                begin
                    nxt.pc     = cur.pc + 16'h0001;
                    nxt.st     = ST_RUN;
                    nxt.retire = 1'b1;
                end
            end
            default:
            begin
                nxt.st = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            cur <= ST_RST;
        else
            cur <= nxt;
    end

    assign prog_addr = cur.pc;
    assign sreg_out  = cur.sreg;
    assign dbg_data  = cur.dbg;
    assign retire    = cur.retire;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_two;
        !cur.retire ##1 cur.retire;
    endsequence
    sequence s_three;
        !cur.retire [*2] ##1 cur.retire;
    endsequence

    property p_adc_carry;
        ex && (top6 == OP_ADC) |=> cur.sreg[FLG_C] == $past(chk_adc[8])
            && cur.retire;
    endproperty
    a_adc_carry: assert property (p_adc_carry)
        else $error("sum with carry gave wrong carry");

    property p_word_add;
        ex && op_wadd |=> (cur.gpr[$past(fw)] == $past(wsum[7:0]))
            ##0 s_two;
    endproperty
    a_word_add: assert property (p_word_add)
        else $error("word increase wrong value or timing");

    property p_word_sub;
        ex && op_wsub |=> cur.sreg[FLG_C] == $past(pairv < kw) ##0 s_two;
    endproperty
    a_word_sub: assert property (p_word_sub)
        else $error("word decrease borrow or timing wrong");

    property p_sub_res;
        ex && (top6 == OP_SUB) |=> cur.gpr[$past(fd)] == $past(8'(va - vb))
            && cur.sreg[FLG_C] == $past(va < vb);
    endproperty
    a_sub_res: assert property (p_sub_res)
        else $error("difference result or borrow wrong");

    property p_immediate_difference_res;
        ex && (top4 == OP_KSUB) |=> cur.gpr[$past(fi)]
            == $past(8'(vi - kk));
    endproperty
    a_immediate_difference_res: assert property (p_immediate_difference_res)
        else $error("immediate difference wrong");

    property p_logic_v;
        ex && op_log |=> !cur.sreg[FLG_V]
            && cur.sreg[FLG_C] == $past(cur.sreg[FLG_C]);
    endproperty
    a_logic_v: assert property (p_logic_v)
        else $error("logic op left overflow set or touched carry");

    property p_inv;
        ex && op_inv |=> cur.sreg[FLG_C] && cur.gpr[$past(fd)] == ~$past(va);
    endproperty
    a_inv: assert property (p_inv)
        else $error("bit inversion wrong");

    property p_ainv;
        ex && op_ainv |=> cur.gpr[$past(fd)] == $past(8'(ZERO_B - va))
            && cur.sreg[FLG_C] == $past(va != ZERO_B);
    endproperty
    a_ainv: assert property (p_ainv)
        else $error("arith inverse wrong");

    property p_ones;
        ex && op_ones |=> cur.gpr[$past(fi)] == ALL_ONES
            && cur.sreg == $past(cur.sreg);
    endproperty
    a_ones: assert property (p_ones)
        else $error("all ones load wrong or changed flags");

    property p_relj;
        ex && op_relj |=> (prog_addr == $past(rel_tgt)) ##0 s_two;
    endproperty
    a_relj: assert property (p_relj)
        else $error("relative jump target or timing wrong");

    property p_relc;
        ex && op_relc |=> (cur.stk[$past(cur.sp)]
            == $past(cur.pc + 16'h0001)) ##0 s_three;
    endproperty
    a_relc: assert property (p_relc)
        else $error("call push or timing wrong");

    property p_eqsk;
        ex && op_eqsk && (va == vb) |=> !cur.retire ##[1:2] cur.retire;
    endproperty
    a_eqsk: assert property (p_eqsk)
        else $error("equal skip took wrong time");

    property p_inc;
        ex && op_inc |=> cur.gpr[$past(fd)] == $past(8'(va + 8'h01))
            && cur.sreg[FLG_C] == $past(cur.sreg[FLG_C]);
    endproperty
    a_inc: assert property (p_inc)
        else $error("plus one wrong");

    property p_leave;
        ex && (op_lsub || op_lint) |=> !cur.retire [*3] ##1 cur.retire;
    endproperty
    a_leave: assert property (p_leave)
        else $error("return not four cycles");

    property p_cmp;
        ex && op_cmp |=> cur.gpr == $past(cur.gpr);
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("compare wrote a register");
endmodule // albe_core

// ==== logic/albe_pkg.sv ====
// Purpose: constants and state type for the arithmetic/branch exec unit
// Assumes: 16-bit instruction words, one core clock, synchronous reset
// Notes:   status bit positions follow the core status register layout
// Overview of operation
// - add, add-carry: sum to destination, ZCNVH, 1 cycle
// - word increase: pair plus constant, ZCNVS, 2 cycles
// - difference, with borrow: to destination, ZCNVH, 1 cycle
// - immediate difference: minus constant, ZCNVH, 1 cycle
// - immediate difference with borrow: ZCNVH, 1 cycle
// - word decrease: pair minus constant, ZCNVS, 2 cycles
// - conjunction reg or constant: ZNV, 1 cycle
// - disjunction, exclusive disjunction: ZNV, 1 cycle
// - bit inversion: 0xFF minus value, ZCNV
// - arith inverse: 0x00 minus value, ZCNVH
// - set bits by mask: OR constant, ZNV
// - clear bits by mask: AND inverted mask, ZNV
// - zero sign test: value kept, ZNV
// - zero register ZNV; all ones load, no flags
// - relative/pointer jump: two cycles, no flags
// - relative/pointer call: three cycles, no flags
// - equal skip compare: skips next, 1/2/3 cycles
package albe_pkg;
    localparam int unsigned NREG  = 32;
    localparam int unsigned PC_W  = 16;
    localparam int unsigned INS_W = 16;
    localparam int unsigned STK_D = 8;
    localparam int unsigned SP_W  = 3;
    localparam int unsigned FLG_C = 0;
    localparam int unsigned FLG_Z = 1;
    localparam int unsigned FLG_N = 2;
    localparam int unsigned FLG_V = 3;
    localparam int unsigned FLG_S = 4;
    localparam int unsigned FLG_H = 5;
    localparam int unsigned FLG_I = 7;
    localparam logic [PC_W-1:0] PC_RST   = 16'h0000;
    localparam logic [7:0]      SREG_RST = 8'h00;
    localparam logic [7:0]      ALL_ONES = 8'hFF;
    localparam logic [7:0]      ZERO_B   = 8'h00;
    localparam int unsigned CYC_WORD = 2;
    localparam int unsigned CYC_JMP  = 2;
    localparam int unsigned CYC_CALL = 3;
    localparam int unsigned CYC_RET  = 4;
    localparam logic [1:0] W_WORD = 2'(CYC_WORD - 1);
    localparam logic [1:0] W_JMP  = 2'(CYC_JMP - 1);
    localparam logic [1:0] W_CALL = 2'(CYC_CALL - 1);
    localparam logic [1:0] W_RET  = 2'(CYC_RET - 1);
    localparam logic [5:0] OP_CMPB = 6'h01;
    localparam logic [5:0] OP_SUBB = 6'h02;
    localparam logic [5:0] OP_ADD  = 6'h03;
    localparam logic [5:0] OP_EQSK = 6'h04;
    localparam logic [5:0] OP_CMP  = 6'h05;
    localparam logic [5:0] OP_SUB  = 6'h06;
    localparam logic [5:0] OP_ADC  = 6'h07;
    localparam logic [5:0] OP_AND  = 6'h08;
    localparam logic [5:0] OP_XOR  = 6'h09;
    localparam logic [5:0] OP_OR   = 6'h0a;
    localparam logic [3:0] OP_KSBB = 4'h4;
    localparam logic [3:0] OP_KSUB = 4'h5;
    localparam logic [3:0] OP_KOR  = 4'h6;
    localparam logic [3:0] OP_KAND = 4'h7;
    localparam logic [3:0] OP_RELJ = 4'hc;
    localparam logic [3:0] OP_RCAL = 4'hd;
    localparam logic [3:0] OP_LDI  = 4'he;
    localparam logic [6:0] OP_ONE  = 7'h4a;
    localparam logic [3:0] ONE_INV  = 4'h0;
    localparam logic [3:0] ONE_AINV = 4'h1;
    localparam logic [3:0] ONE_INC  = 4'h3;
    localparam logic [3:0] ONE_MIN  = 4'ha;
    localparam logic [7:0] OP_WADD = 8'h96;
    localparam logic [7:0] OP_WSUB = 8'h97;
    localparam logic [15:0] OP_LSUB = 16'h9508;
    localparam logic [15:0] OP_LINT = 16'h9518;
    localparam logic [15:0] OP_PJMP = 16'h9409;
    localparam logic [15:0] OP_ICAL = 16'h9509;
    localparam logic [15:0] TW_M0 = 16'hfc0f;
    localparam logic [15:0] TW_V0 = 16'h9000;
    localparam logic [15:0] TW_M1 = 16'hfe0c;
    localparam logic [15:0] TW_V1 = 16'h940c;
    localparam logic [4:0]  Z_LO  = 5'h1e;
    localparam logic [4:0]  Z_HI  = 5'h1f;

    typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_SKIP} albe_state_e;

    typedef struct packed {
        albe_state_e                     st;
        logic [1:0]                      wcnt;
        logic [PC_W-1:0]                 pc;
        logic [7:0]                      sreg;
        logic [NREG-1:0][7:0]            gpr;
        logic [STK_D-1:0][PC_W-1:0]      stk;
        logic [SP_W-1:0]                 sp;
        logic [7:0]                      dbg;
        logic                            retire;
    } albe_st_s;

    localparam albe_st_s ST_RST = '{st: ST_RUN, pc: PC_RST,
                                    sreg: SREG_RST, default: '0};
endpackage

// ==== test/arith_logic_branch_exec_test.sv ====
// Purpose: self-checking bench for the arithmetic/branch exec unit
// Assumes: bench plays program memory; nop words fill every gap
// Notes:   results are read back through the observation port
`timescale 1ns/1ps
module arith_logic_branch_exec_test;
    import albe_pkg::*;
    logic        sys_clk;
    logic        rst_n;
    logic [15:0] prog_data;
    logic [4:0]  dbg_sel;
    logic [15:0] prog_addr;
    logic [7:0]  sreg_out;
    logic [7:0]  dbg_data;
    logic        retire;
    int          errors;
    int          n_compared;
    int          seed;
    int          op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  s;
    logic [15:0] e;
    logic [15:0] pc0;
    logic [15:0] pcs;
    logic [5:0]  o6 [9] = '{OP_ADD, OP_ADC, OP_SUB, OP_SUBB, OP_CMP, OP_CMPB,
                            OP_AND, OP_OR, OP_XOR};
    logic [3:0]  o4 [4] = '{OP_KSUB, OP_KSBB, OP_KAND, OP_KOR};
    logic [3:0]  o1 [4] = '{ONE_INV, ONE_AINV, ONE_INC, ONE_MIN};

    albe_core albe_core_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .prog_data(prog_data), .dbg_sel(dbg_sel), .prog_addr(prog_addr),
        .sreg_out(sreg_out), .dbg_data(dbg_data), .retire(retire));

    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask

    // nop filler keeps wait cycles honest: it must be ignored
    task automatic exec(input logic [15:0] w, input int n);
        pc0 = prog_addr;
        prog_data = w;
        step();
        prog_data = 16'h0000;
        repeat (n - 1)
        begin
            chk(16'(retire), 16'h0000);
            step();
        end
        chk(16'(retire), 16'h0001);
        if (n == 1)
            chk(prog_addr, pc0 + 16'h0001);
    endtask

    // only the all-ones form of a load exists; others clear then or in
    task automatic ldi(input logic [4:0] r, input logic [7:0] k);
        if (k == ALL_ONES)
            exec({OP_LDI, k[7:4], r[3:0], k[3:0]}, 1);
        else
        begin
            exec({OP_XOR, r[4], r, r[3:0]}, 1);
            exec({OP_KOR, k[7:4], r[3:0], k[3:0]}, 1);
            s[FLG_Z] = (k == ZERO_B);
            s[FLG_N] = k[7];
            s[FLG_V] = 1'b0;
        end
    endtask

    task automatic rd(input logic [4:0] r, input logic [7:0] x);
        dbg_sel = r;
        step();
        step();
        chk({8'h00, dbg_data}, {8'h00, x});
    endtask

    function automatic logic [15:0] enc(input int o, input logic [7:0] k);
        return o < 9 ? {o6[o], 1'b1, 5'd16, 4'd1} :
               o < 13 ? {o4[o - 9], k[7:4], 4'd0, k[3:0]} :
               {OP_ONE, 5'd16, o1[o - 13]};
    endfunction

    // returns {flags, result}; negation is modelled as zero minus value
    function automatic logic [15:0] model(input int o, input logic [7:0] x,
                                          input logic [7:0] y,
                                          input logic [7:0] si);
        logic [8:0] w;
        logic [4:0] h;
        logic [7:0] so;
        logic       cc;
        logic       sb;
        so = si;
        w = 9'h000;
        cc = (o == 1 || o == 3 || o == 5 || o == 10) ? si[FLG_C] : 1'b0;
        sb = o inside {2, 3, 4, 5, 9, 10, 14};
        if (o == 14)
        begin
            y = x;
            x = 8'h00;
        end
        if (o < 6 || o == 9 || o == 10 || o == 14)
        begin
            w = sb ? {1'b0, x} - {1'b0, y} - 9'(cc)
                   : {1'b0, x} + {1'b0, y} + 9'(cc);
            h = sb ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - 5'(cc)
                   : {1'b0, x[3:0]} + {1'b0, y[3:0]} + 5'(cc);
            so[FLG_C] = w[8];
            so[FLG_H] = h[4];
            so[FLG_V] = (sb ^ (x[7] == y[7])) && (w[7] != x[7]);
        end
        else
        begin
            case (o)
                6, 11:   w[7:0] = x & y;
                7, 12:   w[7:0] = x | y;
                8:       w[7:0] = x ^ y;
                13:      w[7:0] = ~x;
                15:      w[7:0] = x + 8'h01;
                default: w[7:0] = x - 8'h01;
            endcase
            so[FLG_V] = o == 15 ? w[7:0] == 8'h80 : o == 16 && w[7:0] == 8'h7f;
            if (o == 13)
                so[FLG_C] = 1'b1;
        end
        so[FLG_Z] = w[7:0] == 8'h00;
        so[FLG_N] = w[7];
        return {so, w[7:0]};
    endfunction

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        test_done();
    end

    initial
    begin
        seed = 81121;
        errors = 0;
        n_compared = 0;
        rst_n = 1'b0;
        prog_data = 16'h0000;
        dbg_sel = 5'd0;
        s = SREG_RST;
        repeat (8) step();
        rst_n = 1'b1;
        // first pass walks every op on the 7f/80/81 corners
        for (int i = 0; i < 80; i++)
        begin
            op = i < 17 ? i : int'($unsigned($random(seed)) % 17);
            a = i < 17 ? 8'h7f + 8'(i % 2) : 8'($random(seed));
            b = i < 17 ? 8'h7f + 8'(i % 3) : 8'($random(seed));
            ldi(5'd16, a);
            ldi(5'd17, b);
            e = model(op, a, b, s);
            exec(enc(op, b), 1);
            s = e[15:8];
            rd(5'd16, op == 4 || op == 5 ? a : e[7:0]);
            chk({8'h00, sreg_out}, {8'h00, s});
        end
        $display("alu test done");
        ldi(5'd24, 8'hff);
        ldi(5'd25, 8'hff);
        exec({OP_WADD, 4'd0, 4'd1}, CYC_WORD);
        rd(5'd25, 8'h00);
        s[4:0] = 5'b00011;
        chk({8'h00, sreg_out}, {8'h00, s});
        exec({OP_WSUB, 4'd0, 4'd1}, CYC_WORD);
        rd(5'd24, 8'hff);
        s[4:0] = 5'b10101;
        chk({8'h00, sreg_out}, {8'h00, s});
        $display("word test done");
        exec({OP_RELJ, 12'h005}, CYC_JMP);
        chk(prog_addr, pc0 + 16'h0006);
        exec({OP_RELJ, 12'hffd}, CYC_JMP);
        chk(prog_addr, pc0 - 16'h0002);
        ldi(Z_LO, 8'h40);
        ldi(Z_HI, 8'h01);
        exec(OP_PJMP, CYC_JMP);
        chk(prog_addr, 16'h0140);
        exec({OP_RCAL, 12'h010}, CYC_CALL);
        pcs = pc0 + 16'h0001;
        chk(prog_addr, pc0 + 16'h0011);
        exec(OP_LSUB, CYC_RET);
        chk(prog_addr, pcs);
        exec(OP_ICAL, CYC_CALL);
        pcs = pc0 + 16'h0001;
        chk(prog_addr, 16'h0140);
        exec(OP_LINT, CYC_RET);
        chk(prog_addr, pcs);
        s[FLG_I] = 1'b1;
        ldi(5'd16, 8'h33);
        ldi(5'd17, 8'h33);
        exec({OP_AND, 1'b1, 5'd16, 4'd0}, 1);
        rd(5'd16, 8'h33);
        exec({OP_EQSK, 1'b1, 5'd16, 4'd1}, 2);
        chk(prog_addr, pc0 + 16'h0002);
        // a two-word word after an equal compare costs one more cycle
        pc0 = prog_addr;
        prog_data = {OP_EQSK, 1'b1, 5'd16, 4'd1};
        step();
        prog_data = TW_V1;
        chk(16'(retire), 16'h0000);
        step();
        prog_data = 16'h0000;
        chk(16'(retire), 16'h0000);
        step();
        chk(16'(retire), 16'h0001);
        chk(prog_addr, pc0 + 16'h0003);
        ldi(5'd17, 8'h34);
        exec({OP_EQSK, 1'b1, 5'd16, 4'd1}, 1);
        chk({8'h00, sreg_out}, {8'h00, s});
        $display("branch test done");
        test_done();
    end
endmodule // arith_logic_branch_exec_test
